// ==== compare_link_if.sv ====
// Interface joining the timer core to its compare unit.
`timescale 1ns/10ps
interface compare_link_if;
  logic [15:0] count;
  logic tick;
  logic count_wr;
  logic [15:0] cmp_value;
  logic [3:0] mode;
  logic ctrl_clear;
  logic adc_enabled;
  logic match;
  logic out_level;
  logic out_drive;
  logic adc_trigger;
  logic period_clear;
  modport unit (input count, tick, count_wr, cmp_value, mode, ctrl_clear, adc_enabled,
                output match, out_level, out_drive, adc_trigger, period_clear);
  modport core (output count, tick, count_wr, cmp_value, mode, ctrl_clear, adc_enabled,
                input match, out_level, out_drive, adc_trigger, period_clear);
endinterface

// ==== compare_timer.sv ====
// Top of the 16-bit timer with compare unit and Wishbone register slave.
// Contract
// - The counter is 16 bits, read and written as high and low bytes.
// - Writing either count byte loads that byte of the counter at once.
// - Off when on bit clear; with gate enable it counts only while gated.
// - Clock select: 11 slow oscillator, 10 pin, 01 system, 00 instruction clock.
// - System clock source steps four counts per instruction cycle.
// - Internal sources advance through the prescaler.
// - External pin counts rising edges, synchronised or asynchronous.
// - Pin counting needs a falling edge after enable, write or disable.
// - On the instruction clock the count holds in Sleep and resumes after.
// - With the external source the timer keeps running in Sleep.
// - The compare pair is checked against the counter for equality.
// - A match performs the mode action and sets the compare flag.
// - Clearing the compare control register drives the output latch low.
// - Mode 1010 only sets the flag and leaves the pin alone.
// - Mode 1011 resets the counter and starts a conversion if enabled.
// - Trigger fires at the match; counter clears on the next tick.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module compare_timer #(
  parameter int COUNT_W = 16,
  parameter int PS_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin_i,
  input wire logic gate_input_pin_i,
  input wire logic low_freq_internal_osc_i,
  input wire logic sleep_i,
  input wire logic adc_enabled_i,
  output logic compare_output_pin_o,
  output logic compare_output_oe_o,
  output logic adc_trigger_o,
  output logic irq_o
);
  logic [7:0] counter_control_reg;
  logic [7:0] gate_control_reg;
  logic [15:0] count;
  logic [7:0] compare_value_low;
  logic [7:0] compare_value_high;
  logic [3:0] compare_mode_field;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic wr_en;
  logic wr_lo;
  logic wr_hi;
  logic counter_on_bit;
  logic gate_enable_bit;
  logic gate_open;
  logic run;
  logic tick;
  logic overflow;
  logic [7:0] rdata;
  logic [1:0] clr_bits;
  compare_link_if lnk ();

  if (COUNT_W != 16) begin : g_bad_width
    $error("compare_timer: COUNT_W must be 16, the counter is two bytes");
  end

  // The prescale field sits between the async bit and the clock select.
  if (PS_W < 1 || PS_W > 2) begin : g_bad_ps
    $error("compare_timer: PS_W must be 1 or 2, the prescale field has two bits");
  end

  // Bus write strobe: a write takes effect on the edge where ack is seen high.
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_lo = wr_en && wb_adr_i == timer_pkg::OFS_COUNT_LO;
  assign wr_hi = wr_en && wb_adr_i == timer_pkg::OFS_COUNT_HI;
  assign clr_bits = (wr_en && wb_adr_i == timer_pkg::OFS_IRQ_STATUS) ? wb_dat_i[1:0] : 2'h0;

  // Enable table: off unless on, gate only matters when gate enable is set.
  assign counter_on_bit = counter_control_reg[timer_pkg::CTRL_ON_BIT];
  assign gate_enable_bit = gate_control_reg[timer_pkg::GATE_EN_BIT];
  assign gate_open = gate_input_pin_i == gate_control_reg[timer_pkg::GATE_POL_BIT];
  assign run = counter_on_bit && (!gate_enable_bit || gate_open);

  tick_source #(
    .PS_W(PS_W)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_sel_i(counter_control_reg[timer_pkg::CTRL_CS_LSB +: 2]),
    .ps_i(counter_control_reg[timer_pkg::CTRL_PS_LSB +: PS_W]),
    .async_i(counter_control_reg[timer_pkg::CTRL_ASYNC_BIT]),
    .on_i(counter_on_bit),
    .run_i(run),
    .sleep_i(sleep_i),
    .cnt_wr_i(wr_lo || wr_hi),
    .ext_pin_i(external_count_pin_i),
    .lfosc_i(low_freq_internal_osc_i),
    .tick_o(tick)
  );

  // Signals handed to the compare unit.
  assign lnk.count = count;
  assign lnk.tick = tick;
  assign lnk.count_wr = wr_lo || wr_hi;
  assign lnk.cmp_value = {compare_value_high, compare_value_low};
  assign lnk.mode = compare_mode_field;
  assign lnk.ctrl_clear = wr_en && wb_adr_i == timer_pkg::OFS_CMP_CTRL &&
                          wb_dat_i[7:0] == 8'h00;
  assign lnk.adc_enabled = adc_enabled_i;

  compare_unit u_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk)
  );

  // Control registers written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_control_reg <= timer_pkg::CTRL_RST;
      gate_control_reg <= timer_pkg::GATE_RST;
      compare_value_low <= timer_pkg::CMP_RST[7:0];
      compare_value_high <= timer_pkg::CMP_RST[15:8];
      compare_mode_field <= timer_pkg::MODE_RST;
      irq_mask <= timer_pkg::IRQ_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        timer_pkg::OFS_CTRL: counter_control_reg <= wb_dat_i[7:0];
        timer_pkg::OFS_GATE: gate_control_reg <= wb_dat_i[7:0];
        timer_pkg::OFS_CMP_LO: compare_value_low <= wb_dat_i[7:0];
        timer_pkg::OFS_CMP_HI: compare_value_high <= wb_dat_i[7:0];
        timer_pkg::OFS_CMP_CTRL: compare_mode_field <= wb_dat_i[3:0];
        timer_pkg::OFS_IRQ_MASK: irq_mask <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // The counter: byte writes load directly, ticks increment or apply a period clear.
  // With the system clock as source and prescale 00 it steps every clock, four per instruction cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= timer_pkg::COUNT_RST;
    end else if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        count[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi) begin
        count[15:8] <= wb_dat_i[7:0];
      end
    end else if (tick) begin
      if (lnk.period_clear) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
  assign overflow = tick && !lnk.period_clear && !(wr_lo || wr_hi) && count == 16'hffff;

  // Sticky interrupt flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= timer_pkg::IRQ_RST;
    end else begin
      irq_status[timer_pkg::IRQ_CMP_BIT] <= lnk.match ||
        (irq_status[timer_pkg::IRQ_CMP_BIT] && !clr_bits[timer_pkg::IRQ_CMP_BIT]);
      irq_status[timer_pkg::IRQ_OVF_BIT] <= overflow ||
        (irq_status[timer_pkg::IRQ_OVF_BIT] && !clr_bits[timer_pkg::IRQ_OVF_BIT]);
    end
  end

  // Registered outputs toward the pins and the interrupt controller.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      compare_output_pin_o <= 1'b0;
      compare_output_oe_o <= 1'b0;
      adc_trigger_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
      compare_output_pin_o <= lnk.out_level;
      compare_output_oe_o <= lnk.out_drive;
      adc_trigger_o <= lnk.adc_trigger;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    unique case (wb_adr_i)
      timer_pkg::OFS_CTRL: rdata = counter_control_reg;
      timer_pkg::OFS_GATE: rdata = gate_control_reg;
      timer_pkg::OFS_COUNT_LO: rdata = count[7:0];
      timer_pkg::OFS_COUNT_HI: rdata = count[15:8];
      timer_pkg::OFS_CMP_LO: rdata = compare_value_low;
      timer_pkg::OFS_CMP_HI: rdata = compare_value_high;
      timer_pkg::OFS_CMP_CTRL: rdata = {4'h0, compare_mode_field};
      timer_pkg::OFS_IRQ_STATUS: rdata = {6'h00, irq_status};
      timer_pkg::OFS_IRQ_MASK: rdata = {6'h00, irq_mask};
      default: rdata = 8'h00;
    endcase
  end

  // Classic Wishbone: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= {24'h000000, rdata};
      end
    end
  end

  chk_off_holds_count:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (!counter_on_bit && !wr_lo && !wr_hi) |=> $stable(count))
    else $error("Counter moved while off.");
  chk_gate_closed_holds:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_enable_bit && !gate_open && !wr_lo && !wr_hi) |=> $stable(count))
    else $error("Counter moved while gate closed.");
  chk_sys_clock_step:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (run && !sleep_i && !wr_lo && !wr_hi && !lnk.period_clear &&
       counter_control_reg[7:4] == 4'h4)
      |=> count == $past(count) + 16'h0001)
    else $error("System clock source did not step every cycle.");
  chk_sleep_holds_instr:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_i && counter_control_reg[7:6] == timer_pkg::CS_INSTR && !wr_lo && !wr_hi)
      |=> $stable(count))
    else $error("Counter moved in Sleep on instruction clock.");
  chk_count_write_loads:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wr_lo |=> count[7:0] == $past(wb_dat_i[7:0]))
    else $error("Low byte write did not load the counter.");
  chk_match_sets_flag:
    assert property (@(posedge clk_i) disable iff (rst_i)
      lnk.match |=> irq_status[timer_pkg::IRQ_CMP_BIT] ##1
      (irq_o || !irq_mask[timer_pkg::IRQ_CMP_BIT]))
    else $error("Match did not set the compare flag.");
  chk_flag_sticky:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_status[timer_pkg::IRQ_CMP_BIT] && !clr_bits[timer_pkg::IRQ_CMP_BIT])
      |=> irq_status[timer_pkg::IRQ_CMP_BIT])
    else $error("Compare flag dropped without a clear.");
  chk_period_clear:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (lnk.period_clear && tick && !wr_lo && !wr_hi) |=> count == 16'h0000)
    else $error("Period clear not applied on the tick.");
  chk_high_write_loads:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hi |=> count[15:8] == $past(wb_dat_i[7:0]))
    else $error("High byte write did not load the counter.");
  chk_trigger_needs_adc:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !adc_enabled_i |-> ##2 !adc_trigger_o)
    else $error("Conversion started while the converter was off.");
endmodule

// ==== compare_unit.sv ====
// Compare unit: match detection, output latch and conversion trigger.
`timescale 1ns/10ps
module compare_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  compare_link_if.unit lnk
);
  logic eq, eq_prev;

  // True for the codes that use the compare function.
  function automatic logic is_compare(input logic [3:0] m);
    return m == timer_pkg::MODE_TOGGLE || m == timer_pkg::MODE_SET ||
           m == timer_pkg::MODE_CLEAR || m == timer_pkg::MODE_SWINT ||
           m == timer_pkg::MODE_TRIGGER;
  endfunction

  // Equality is checked every cycle; a match is its rising edge.
  assign eq = (lnk.count == lnk.cmp_value);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_prev <= 1'b0;
    end else begin
      eq_prev <= eq;
    end
  end
  assign lnk.match = eq && !eq_prev && is_compare(lnk.mode);

  // Output latch, separate from any port latch.
  always_ff @(posedge clk_i) begin
    if (rst_i || lnk.ctrl_clear) begin
      lnk.out_level <= 1'b0;
    end else if (lnk.match) begin
      if (lnk.mode == timer_pkg::MODE_TOGGLE) begin
        lnk.out_level <= !lnk.out_level;
      end else if (lnk.mode == timer_pkg::MODE_SET) begin
        lnk.out_level <= 1'b1;
      end else if (lnk.mode == timer_pkg::MODE_CLEAR) begin
        lnk.out_level <= 1'b0;
      end
    end
  end

  // The pin is driven only in the toggle, set and clear modes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lnk.out_drive <= 1'b0;
    end else begin
      lnk.out_drive <= lnk.mode == timer_pkg::MODE_TOGGLE ||
                       lnk.mode == timer_pkg::MODE_SET || lnk.mode == timer_pkg::MODE_CLEAR;
    end
  end

  // Trigger pulses right after the match; the counter clear waits for the next tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lnk.adc_trigger <= 1'b0;
      lnk.period_clear <= 1'b0;
    end else begin
      lnk.adc_trigger <= lnk.match && lnk.mode == timer_pkg::MODE_TRIGGER &&
                         lnk.adc_enabled;
      if (lnk.match && lnk.mode == timer_pkg::MODE_TRIGGER) begin
        lnk.period_clear <= 1'b1;
      end else if (lnk.tick || lnk.count_wr) begin
        lnk.period_clear <= 1'b0;
      end
    end
  end

  chk_trigger_on_match:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (lnk.match && lnk.mode == timer_pkg::MODE_TRIGGER && lnk.adc_enabled) |=> lnk.adc_trigger)
    else $error("Conversion trigger missing after match.");
  chk_swint_no_drive:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (lnk.mode == timer_pkg::MODE_SWINT) ##1 (lnk.mode == timer_pkg::MODE_SWINT)
      |-> !lnk.out_drive)
    else $error("Pin driven in software interrupt mode.");
  chk_clear_forces_low:
    assert property (@(posedge clk_i) disable iff (rst_i)
      lnk.ctrl_clear |=> !lnk.out_level)
    else $error("Output latch not low after control clear.");
endmodule

// ==== ext_side_model.sv ====
// Model of the external count source and of the converter start input.
`timescale 1ns/10ps
module ext_side_model (
  input wire logic clk_i,
  input wire logic adc_trigger_i,
  output logic pin_o,
  output int starts_o
);
  initial begin
    pin_o = 1'b1;
    starts_o = 0;
  end
  // Counts conversion starts, one for each trigger pulse.
  always @(posedge clk_i) begin
    if (adc_trigger_i === 1'b1) begin
      starts_o <= starts_o + 1;
    end
  end
  // Sets the pin to a level.
  task automatic level(input logic v);
    pin_o <= v;
  endtask
  // Gives n full pulses with the given width, slow enough for the synchroniser.
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
      pin_o <= 1'b1;
    end
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the compare timer.
`timescale 1ns/10ps
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, gate, lfosc, sleep, adc_en, pin, oe, trig, irq;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  wire logic ext;
  int starts, fails, comparisons;

  compare_timer compare_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_count_pin_i(ext), .gate_input_pin_i(gate),
    .low_freq_internal_osc_i(lfosc), .sleep_i(sleep), .adc_enabled_i(adc_en),
    .compare_output_pin_o(pin), .compare_output_oe_o(oe), .adc_trigger_o(trig), .irq_o(irq));
  ext_side_model ext_side_model_i (.clk_i(clk_i), .adc_trigger_i(trig), .pin_o(ext),
    .starts_o(starts));

  // Makes the system clock and a slow oscillator of sixteen cycles.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always begin
    repeat (8) @(posedge clk_i);
    lfosc <= ~lfosc;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts that depend on pipeline latency are judged within a window.
  task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Runs one classic Wishbone cycle and keeps the read data in q.
  // It waits for ack with no limit of its own; the watchdog ends a hang.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic zero();
    wr(timer_pkg::OFS_COUNT_LO, 8'h00);
    wr(timer_pkg::OFS_COUNT_HI, 8'h00);
  endtask
  // Counts for a fixed span with one control setting and returns the low byte.
  task automatic span(input logic [7:0] c, input int n);
    zero();
    wr(timer_pkg::OFS_CTRL, c);
    repeat (n) @(posedge clk_i);
    wr(timer_pkg::OFS_CTRL, 8'h00);
    rd(timer_pkg::OFS_COUNT_LO);
  endtask

  task automatic t_reset();
    rd(timer_pkg::OFS_CTRL);
    cmp(q, 32'h0);
    rd(timer_pkg::OFS_COUNT_HI);
    cmp(q, 32'h0);
    wr(8'h30, 8'hff);
    rd(8'h30);
    cmp(q, 32'h0);
    cmp({pin, oe, trig, irq}, 4'h0);
  endtask
  // Byte loads land at once and an idle counter holds them.
  task automatic t_bytes();
    wr(timer_pkg::OFS_COUNT_LO, 8'h34);
    wr(timer_pkg::OFS_COUNT_HI, 8'h12);
    rd(timer_pkg::OFS_COUNT_HI);
    cmp(q, 32'h12);
    repeat (20) @(posedge clk_i);
    rd(timer_pkg::OFS_COUNT_LO);
    cmp(q, 32'h34);
  endtask
  task automatic t_gate();
    wr(timer_pkg::OFS_GATE, 8'hc0);
    span(8'h01, 50);
    cmp(q, 32'h0);
    gate <= 1'b1;
    span(8'h01, 50);
    cmp_rng(q, 11, 15);
    wr(timer_pkg::OFS_GATE, 8'h00);
  endtask
  // System, instruction, prescaled and slow oscillator sources in turn.
  task automatic t_rates();
    logic [7:0] c [4] = '{8'h41, 8'h01, 8'h11, 8'hc1};
    int lo [4] = '{96, 23, 11, 5};
    int hi [4] = '{106, 28, 14, 8};
    for (int i = 0; i < 4; i++) begin
      span(c[i], 100);
      cmp_rng(q, lo[i], hi[i]);
    end
  endtask
  // A rise with no fall since enable is ignored; sync and async paths, async in Sleep.
  task automatic t_ext();
    for (int a = 0; a < 2; a++) begin
      zero();
      ext_side_model_i.level(1'b0);
      sleep <= a[0];
      // Lets the fall pass the synchroniser while the counter is still off.
      repeat (4) @(posedge clk_i);
      wr(timer_pkg::OFS_CTRL, 8'h81 | (a[0] << 2));
      ext_side_model_i.level(1'b1);
      repeat (8) @(posedge clk_i);
      ext_side_model_i.pulse(3, 4);
      repeat (10) @(posedge clk_i);
      wr(timer_pkg::OFS_CTRL, 8'h00);
      rd(timer_pkg::OFS_COUNT_LO);
      cmp(q, 32'h3);
      sleep <= 1'b0;
    end
  endtask
  task automatic t_sleep();
    sleep <= 1'b1;
    span(8'h01, 40);
    cmp(q, 32'h0);
    sleep <= 1'b0;
    span(8'h01, 40);
    cmp_rng(q, 9, 12);
  endtask
  // One match run: pin, drive, sticky flag, interrupt level, then flag clear.
  task automatic run(input logic [3:0] m, input logic p, input logic o, input logic i);
    wr(timer_pkg::OFS_CTRL, 8'h00);
    zero();
    wr(timer_pkg::OFS_CMP_CTRL, {4'h0, m});
    wr(timer_pkg::OFS_CTRL, 8'h01);
    repeat (90) @(posedge clk_i);
    cmp(oe, o);
    if (o) begin
      cmp(pin, p);
    end
    rd(timer_pkg::OFS_IRQ_STATUS);
    cmp(q, 32'h1);
    cmp(irq, i);
    wr(timer_pkg::OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_i);
    cmp(irq, 1'b0);
  endtask
  task automatic t_compare();
    wr(timer_pkg::OFS_CMP_LO, 8'h10);
    wr(timer_pkg::OFS_CMP_HI, 8'h00);
    wr(timer_pkg::OFS_IRQ_MASK, 8'h01);
    run(timer_pkg::MODE_SET, 1'b1, 1'b1, 1'b1);
    run(timer_pkg::MODE_CLEAR, 1'b0, 1'b1, 1'b1);
    run(timer_pkg::MODE_TOGGLE, 1'b1, 1'b1, 1'b1);
    wr(timer_pkg::OFS_IRQ_MASK, 8'h00);
    run(timer_pkg::MODE_SWINT, 1'b0, 1'b0, 1'b0);
    wr(timer_pkg::OFS_CMP_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    cmp(pin, 1'b0);
  endtask
  // The compare value acts as a period; starts only reach an enabled converter.
  task automatic t_trigger();
    int s;
    for (int e = 1; e >= 0; e--) begin
      adc_en <= e[0];
      wr(timer_pkg::OFS_CMP_CTRL, {4'h0, timer_pkg::MODE_TRIGGER});
      s = starts;
      span(8'h01, 200);
      cmp_rng(q, 0, 16);
      cmp_rng(starts - s, 2 * e, 3 * e);
      cmp(oe, 1'b0);
    end
  endtask

  task automatic print_verdict();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a six cycle reset.
  initial begin
    {rst_i, cyc, stb, we, gate, lfosc, sleep, adc_en} = 8'h80;
    adr = 8'h00;
    dat = 32'h0;
    fails = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_bytes();
    t_gate();
    t_rates();
    t_ext();
    t_sleep();
    t_compare();
    t_trigger();
    print_verdict();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule

// ==== tick_source.sv ====
// Clock source selection, prescaler and external edge handling of the timer.
`timescale 1ns/10ps
module tick_source #(
  parameter int PS_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [PS_W-1:0] ps_i,
  input wire logic async_i,
  input wire logic on_i,
  input wire logic run_i,
  input wire logic sleep_i,
  input wire logic cnt_wr_i,
  input wire logic ext_pin_i,
  input wire logic lfosc_i,
  output wire logic tick_o
);
  logic [1:0] instr_cnt;
  logic instr_en;
  logic ext_s1, ext_s2, ext_a, ext_prev, ext_sel, ext_rise, ext_fall;
  logic armed, lf_prev, lf_rise, src_event;
  logic [PS_W-1:0] ps_cnt;

  if (PS_W < 1) begin : g_bad_ps
    $error("tick_source: PS_W must be at least 1");
  end

  // Free divider giving one instruction-clock enable every four system clocks.
  always_ff @(posedge clk_i) begin
    if (rst_i || instr_en) begin
      instr_cnt <= 2'h0;
    end else begin
      instr_cnt <= instr_cnt + 2'h1;
    end
  end
  assign instr_en = (instr_cnt == 2'(timer_pkg::INSTR_DIV_CYCLES - 1));

  // Synchronised and unsynchronised copies of the external pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_a <= 1'b0;
      ext_prev <= 1'b0;
      lf_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_pin_i;
      ext_s2 <= ext_s1;
      ext_a <= ext_pin_i;
      ext_prev <= ext_sel;
      lf_prev <= lfosc_i;
    end
  end
  assign ext_sel = async_i ? ext_a : ext_s2;
  assign ext_rise = ext_sel && !ext_prev;
  assign ext_fall = !ext_sel && ext_prev;
  assign lf_rise = lfosc_i && !lf_prev;

  // A falling edge must be seen before the first counted rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_i || cnt_wr_i) begin
      armed <= 1'b0;
    end else if (ext_fall) begin
      armed <= 1'b1;
    end
  end

  // Source events; instruction and system clocks stop in Sleep, the external pin and slow oscillator keep counting.
  always_comb begin
    unique case (src_sel_i)
      timer_pkg::CS_INSTR: src_event = instr_en && !sleep_i;
      timer_pkg::CS_SYS: src_event = !sleep_i;
      timer_pkg::CS_EXT: src_event = ext_rise && armed;
      timer_pkg::CS_LFOSC: src_event = lf_rise;
    endcase
  end

  // Prescaler dividing source events by ps_i plus one.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || cnt_wr_i || tick_o) begin
      ps_cnt <= '0;
    end else if (src_event) begin
      ps_cnt <= ps_cnt + 1'b1;
    end
  end
  assign tick_o = run_i && src_event && (ps_cnt >= ps_i);

  chk_arm_blocks_tick:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (src_sel_i == timer_pkg::CS_EXT && !armed) |-> !tick_o)
    else $error("External edge counted before a falling edge.");
endmodule

// ==== timer_pkg.sv ====
// Register map, field positions, encodings and timing constants of the compare timer.
package timer_pkg;
  // Byte addresses of the registers on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GATE = 8'h04;
  localparam logic [7:0] OFS_COUNT_LO = 8'h08;
  localparam logic [7:0] OFS_COUNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CMP_LO = 8'h10;
  localparam logic [7:0] OFS_CMP_HI = 8'h14;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Fields of the counter control register.
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_ASYNC_BIT = 2;
  localparam int CTRL_OSCEN_BIT = 3;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_CS_LSB = 6;
  // Fields of the gate control register.
  localparam int GATE_POL_BIT = 6;
  localparam int GATE_EN_BIT = 7;
  // Interrupt status and mask bits.
  localparam int IRQ_CMP_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  // Values after reset.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Clock source select codes.
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_EXT = 2'h2;
  localparam logic [1:0] CS_LFOSC = 2'h3;
  // Compare mode codes.
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'ha;
  localparam logic [3:0] MODE_TRIGGER = 4'hb;
  // The instruction clock is the system clock divided by four.
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_PERIOD_NS = 40;
  localparam int INSTR_DIV_CYCLES = INSTR_PERIOD_NS / CLK_PERIOD_NS;
endpackage
